// ==== design/sco_pkg.sv ====
// package: constants for the system configuration options block
package sco_pkg;
  // ---------------------------------------------------------------
  // register map (printed offsets are not word multiples: indices)
  // ---------------------------------------------------------------
  localparam logic [7:0]  OPT_TWO_IDX     = 8'h38;
  localparam logic [7:0]  OPT_ONE_IDX     = 8'h39;
  localparam logic [11:0] OPT_TWO_ADDR    = {2'h0, OPT_TWO_IDX, 2'h0};
  localparam logic [11:0] OPT_ONE_ADDR    = {2'h0, OPT_ONE_IDX, 2'h0};
  localparam logic [11:0] MODE_ADDR       = 12'h100;
  localparam logic [7:0]  OPT_ONE_RESET   = 8'h10;
  localparam logic [7:0]  OPT_TWO_RESET   = 8'h00;
  // ---------------------------------------------------------------
  // field positions, first options register
  // ---------------------------------------------------------------
  localparam int ONE_CONV_PWR    = 7;
  localparam int ONE_PUMP_CLK    = 6;
  localparam int ONE_IRQ_EDGE    = 5;
  localparam int ONE_START_DELAY = 4;
  localparam int ONE_MON_EN      = 3;
  localparam int ONE_MON_FORCE   = 2;
  localparam int ONE_WDOG_HI     = 1;
  localparam int ONE_WDOG_LO     = 0;
  // time-protected bits: edge, delay, forced monitor, watchdog rate
  localparam logic [7:0] ONE_PROT_MASK = 8'h37;
  // ---------------------------------------------------------------
  // field positions, second options register
  // ---------------------------------------------------------------
  localparam int TWO_STROBE_HI  = 7;
  localparam int TWO_OPEN_DRAIN = 6;
  localparam int TWO_STRETCH    = 5;
  localparam int TWO_VIS        = 4;
  localparam int TWO_BIT_ORDER  = 3;
  localparam int TWO_EXTRA_DIV  = 2;
  localparam int TWO_AUX_HI     = 1;
  localparam int TWO_AUX_LO     = 0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PROT_WINDOW_CYC = 64;
  localparam logic [6:0] PROT_WINDOW = 7'(PROT_WINDOW_CYC);
  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCO_SINGLE = 2'h0,
    SCO_EXPAND = 2'h1,
    SCO_BOOT   = 2'h2,
    SCO_TEST   = 2'h3
  } sco_mode_t;
  localparam logic [1:0] MODE_RESET = 2'h0;
endpackage : sco_pkg

// ==== design/sco_top.sv ====
// module: system configuration options registers with APB access
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
//
// Functional notes
// R1 - protected option bits: one write, 64 cycles
// R2 - special modes lift write protection
// R3 - first register 0x39, resets to 0x10
// R4 - bit 7 powers the converter
// R5 - software waits 100us after power-up
// R6 - charge pump clock: RC or E
// R7 - software picks RC below 1MHz
// R8 - interrupt pin edge or level
// R9 - startup delay bit, set by reset
// R10 - software clears monitor before stop
// R11 - forced monitor stays on until reset
// R12 - forced monitor triggers clock failure reset
// R13 - bits 1:0 select watchdog rate
// R14 - second register 0x38, bit4 mode reset
// R15 - instruction strobe drive-high option
// R16 - port C open-drain select
// R17 - stretch off-chip accesses, mode-limited
// R18 - visibility bit reset and write limits
// R19 - visibility in expanded, not when secure
// R20 - single-chip: visibility bit suppresses E
// R21 - serial bit order and extra divide
// R22 - aux clock divide 1,4,6,8
// R23 - software waits 16 cycles after divide
// R24 - late protected writes ignored silently
module sco_top (
  input  wire logic        clk_in,          // 250 MHz clock
  input  wire logic        rstn_in,         // async reset, active low
  input  wire logic        psel_in,         // apb select
  input  wire logic        penable_in,      // apb enable
  input  wire logic        pwrite_in,       // apb direction
  input  wire logic [11:0] paddr_in,        // apb byte address
  input  wire logic [31:0] pwdata_in,       // apb write data
  output logic      [31:0] prdata_out,      // apb read data
  output logic             pready_out,      // apb ready
  output logic             pslverr_out,     // apb error
  input  wire logic        secure_in,       // secure expanded mode pin
  input  wire logic        clk_slow_in,     // clock monitor: clock failed
  input  wire logic [15:0] ext_addr_in,     // off-chip access address
  input  wire logic        rom_high_map_in, // rom mapping latch
  output logic             converter_power_up_out,       // a/d power
  output logic             charge_pump_clock_select_out, // rc clock
  output logic             interrupt_pin_edge_select_out,// edge mode
  output logic             startup_delay_enable_out,     // osc delay
  output logic             clock_monitor_active_out,     // monitor on
  output logic             clock_fail_reset_out,         // fail reset
  output logic      [1:0]  watchdog_rate_select_out,     // cop rate
  output logic             instr_strobe_drive_high_out,  // strobe hi
  output logic             port_c_open_drain_out,        // wired-or
  output logic             stretch_active_out,           // stretch
  output logic             internal_read_visibility_out, // vis on
  output logic             e_clock_suppress_out,         // e held low
  output logic             serial_bit_order_out,         // lsb first
  output logic             serial_extra_divide_out,      // div by 4
  output logic      [1:0]  aux_clock_divide_out,         // aux code
  output logic      [3:0]  aux_divide_ratio_out          // 1,4,6,8
);
  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] slow_sync_reg;
  logic [1:0] sec_sync_reg;
  logic [1:0] romh_sync_reg;
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      slow_sync_reg <= 2'h0;
      sec_sync_reg  <= 2'h0;
      romh_sync_reg <= 2'h0;
    end else begin
      slow_sync_reg <= {slow_sync_reg[0], clk_slow_in};
      sec_sync_reg  <= {sec_sync_reg[0], secure_in};
      romh_sync_reg <= {romh_sync_reg[0], rom_high_map_in};
    end
  end
  logic clk_slow;
  logic secure;
  logic rom_high;
  assign clk_slow = slow_sync_reg[1];
  assign secure   = sec_sync_reg[1];
  assign rom_high = romh_sync_reg[1];

  // ---------------------------------------------------------------
  // protection window
  // ---------------------------------------------------------------
  logic window_open;
  sco_window u_window (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_reg),
    .open_out (window_open)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic access;
  logic wr;
  logic hit_one;
  logic hit_two;
  logic hit_mode;
  assign access   = psel_in && penable_in;
  assign wr       = access && pwrite_in;
  assign hit_one  = (paddr_in == sco_pkg::OPT_ONE_ADDR);
  assign hit_two  = (paddr_in == sco_pkg::OPT_TWO_ADDR);
  assign hit_mode = (paddr_in == sco_pkg::MODE_ADDR);

  // ---------------------------------------------------------------
  // operating mode register
  // ---------------------------------------------------------------
  sco_pkg::sco_mode_t mode_reg;
  logic mode_load_reg;
  logic special;
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_reg <= sco_pkg::sco_mode_t'(sco_pkg::MODE_RESET);
    end else if (wr && hit_mode && mode_load_reg) begin
      mode_reg <= sco_pkg::sco_mode_t'(pwdata_in[1:0]);
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_load_reg <= 1'b1;
    end else if (wr && hit_mode) begin
      mode_load_reg <= 1'b0;
    end
  end
  assign special = (mode_reg == sco_pkg::SCO_BOOT) ||
                   (mode_reg == sco_pkg::SCO_TEST);

  // ---------------------------------------------------------------
  // first options register
  // ---------------------------------------------------------------
  logic [7:0] one_reg;
  logic [7:0] one_next;
  logic       prot_used_reg;
  logic       prot_ok;
  assign prot_ok = special || (window_open && !prot_used_reg); // R1 R2 R24

  always_comb begin
    one_next = one_reg;
    if (prot_ok) begin
      one_next = pwdata_in[7:0]; // R1 R2
    end else begin
      one_next = (pwdata_in[7:0] & ~sco_pkg::ONE_PROT_MASK) |
                 (one_reg & sco_pkg::ONE_PROT_MASK); // R24
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      one_reg <= sco_pkg::OPT_ONE_RESET; // R3 R9
    end else if (wr && hit_one) begin
      one_reg <= one_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prot_used_reg <= 1'b0;
    end else if (wr && hit_one && !special) begin
      prot_used_reg <= 1'b1; // R1
    end
  end

  // ---------------------------------------------------------------
  // second options register
  // ---------------------------------------------------------------
  logic [7:0] two_reg;
  logic       vis_used_reg;
  logic       vis_init_reg;
  logic       vis_ok;
  assign vis_ok = special || !vis_used_reg; // R18

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      two_reg <= sco_pkg::OPT_TWO_RESET;
    end else if (wr && hit_two) begin
      two_reg[7:5] <= pwdata_in[7:5];
      two_reg[3:0] <= pwdata_in[3:0];
      if (vis_ok) begin
        two_reg[sco_pkg::TWO_VIS] <= pwdata_in[sco_pkg::TWO_VIS]; // R18
      end
    end else if (vis_init_reg && mode_reg == sco_pkg::SCO_TEST) begin
      two_reg[sco_pkg::TWO_VIS] <= 1'b1; // R14 R18
    end
  end

  // held until the first access to an address other than the mode register
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      vis_init_reg <= 1'b1;
    end else if (access && !hit_mode) begin
      vis_init_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      vis_used_reg <= 1'b0;
    end else if (wr && hit_two && !special) begin
      vis_used_reg <= 1'b1; // R18
    end
  end

  // ---------------------------------------------------------------
  // forced clock monitor latch
  // ---------------------------------------------------------------
  logic forced_reg;
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      forced_reg <= 1'b0;
    end else if (one_reg[sco_pkg::ONE_MON_FORCE]) begin
      forced_reg <= 1'b1; // R11
    end
  end

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in &&
                     !(hit_one || hit_two || hit_mode);
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= hit_one  ? {24'h0, one_reg} :
                      hit_two  ? {24'h0, two_reg} :
                      hit_mode ? {30'h0, mode_reg} : 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  logic expanded;
  logic stretch_hit;
  assign expanded    = (mode_reg == sco_pkg::SCO_EXPAND) ||
                       (mode_reg == sco_pkg::SCO_TEST);
  assign stretch_hit = rom_high || ext_addr_in[15]; // R17

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      converter_power_up_out        <= 1'b0;
      charge_pump_clock_select_out  <= 1'b0;
      interrupt_pin_edge_select_out <= 1'b0;
      startup_delay_enable_out      <= 1'b1;
      clock_monitor_active_out      <= 1'b0;
      clock_fail_reset_out          <= 1'b0;
      watchdog_rate_select_out      <= 2'h0;
      instr_strobe_drive_high_out   <= 1'b0;
      port_c_open_drain_out         <= 1'b0;
      stretch_active_out            <= 1'b0;
      internal_read_visibility_out  <= 1'b0;
      e_clock_suppress_out          <= 1'b0;
      serial_bit_order_out          <= 1'b0;
      serial_extra_divide_out       <= 1'b0;
      aux_clock_divide_out          <= 2'h0;
      aux_divide_ratio_out          <= 4'h1;
    end else begin
      converter_power_up_out        <= one_reg[sco_pkg::ONE_CONV_PWR]; // R4
      charge_pump_clock_select_out  <= one_reg[sco_pkg::ONE_PUMP_CLK]; // R6
      interrupt_pin_edge_select_out <= one_reg[sco_pkg::ONE_IRQ_EDGE]; // R8
      startup_delay_enable_out      <= one_reg[sco_pkg::ONE_START_DELAY]; // R9
      clock_monitor_active_out      <= forced_reg ||
                                       one_reg[sco_pkg::ONE_MON_EN]; // R11
      clock_fail_reset_out          <= forced_reg && clk_slow; // R12
      watchdog_rate_select_out      <=
        one_reg[sco_pkg::ONE_WDOG_HI:sco_pkg::ONE_WDOG_LO]; // R13
      instr_strobe_drive_high_out   <= expanded &&
                                       two_reg[sco_pkg::TWO_STROBE_HI]; // R15
      port_c_open_drain_out         <= two_reg[sco_pkg::TWO_OPEN_DRAIN]; // R16
      stretch_active_out            <= expanded && stretch_hit &&
                                       two_reg[sco_pkg::TWO_STRETCH]; // R17
      internal_read_visibility_out  <= expanded && !secure &&
                                       two_reg[sco_pkg::TWO_VIS]; // R19
      e_clock_suppress_out          <= !expanded &&
                                       two_reg[sco_pkg::TWO_VIS]; // R20
      serial_bit_order_out          <= two_reg[sco_pkg::TWO_BIT_ORDER]; // R21
      serial_extra_divide_out       <= two_reg[sco_pkg::TWO_EXTRA_DIV]; // R21
      aux_clock_divide_out          <=
        two_reg[sco_pkg::TWO_AUX_HI:sco_pkg::TWO_AUX_LO]; // R22
      unique case (two_reg[sco_pkg::TWO_AUX_HI:sco_pkg::TWO_AUX_LO])
        2'h0: aux_divide_ratio_out <= 4'h1; // R22
        2'h1: aux_divide_ratio_out <= 4'h4;
        2'h2: aux_divide_ratio_out <= 4'h6;
        2'h3: aux_divide_ratio_out <= 4'h8;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_LATE_WRITE: assert property ( // R24
    @(posedge clk_in) disable iff (!rst_n_reg)
    wr && hit_one && !special && !window_open |=>
    ((one_reg & sco_pkg::ONE_PROT_MASK) ==
     ($past(one_reg) & sco_pkg::ONE_PROT_MASK)))
    else $error("protected bits changed after window");
  AST_ONCE: assert property ( // R1
    @(posedge clk_in) disable iff (!rst_n_reg)
    wr && hit_one && !special && prot_used_reg |=>
    ((one_reg & sco_pkg::ONE_PROT_MASK) ==
     ($past(one_reg) & sco_pkg::ONE_PROT_MASK)))
    else $error("second protected write took effect");
  AST_SPECIAL: assert property ( // R2
    @(posedge clk_in) disable iff (!rst_n_reg)
    wr && hit_one && special |=> one_reg == $past(pwdata_in[7:0]))
    else $error("special mode write lost");
  AST_FORCED: assert property ( // R11
    @(posedge clk_in) disable iff (!rst_n_reg)
    forced_reg |-> ##1 clock_monitor_active_out)
    else $error("forced monitor not active");
  AST_FAIL: assert property ( // R12
    @(posedge clk_in) disable iff (!rst_n_reg)
    forced_reg && clk_slow |=> clock_fail_reset_out)
    else $error("no clock failure reset");
  AST_SECURE: assert property ( // R19
    @(posedge clk_in) disable iff (!rst_n_reg)
    secure |=> !internal_read_visibility_out || !$past(secure))
    else $error("visibility in secure mode");
  AST_ESUP: assert property ( // R20
    @(posedge clk_in) disable iff (!rst_n_reg)
    expanded |=> !e_clock_suppress_out)
    else $error("e suppressed in expanded mode");
  AST_VIS_ONCE: assert property ( // R18
    @(posedge clk_in) disable iff (!rst_n_reg)
    wr && hit_two && vis_used_reg && !special |=>
    $stable(two_reg[sco_pkg::TWO_VIS]))
    else $error("visibility bit rewritten");
  AST_DIV: assert property ( // R22
    @(posedge clk_in) disable iff (!rst_n_reg)
    two_reg[sco_pkg::TWO_AUX_HI:sco_pkg::TWO_AUX_LO] == 2'h3 |=>
    aux_divide_ratio_out == 4'h8)
    else $error("wrong aux divide ratio");
  AST_RESET_DLY: assert property ( // R3
    @(posedge clk_in)
    $rose(rst_n_reg) |-> one_reg == sco_pkg::OPT_ONE_RESET)
    else $error("bad first register reset");
endmodule : sco_top

// ==== design/sco_window.sv ====
// module: 64-cycle write window counter after reset
`timescale 1ns/1ps
module sco_window (
  input  wire logic clk_in,     // clock
  input  wire logic rst_n_in,   // synchronised reset, active low
  output logic      open_out    // high while inside the window
);
  logic [6:0] count_reg;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= 7'h00;
    end else if (count_reg != sco_pkg::PROT_WINDOW) begin
      count_reg <= count_reg + 7'h01;
    end
  end

  assign open_out = (count_reg != sco_pkg::PROT_WINDOW);
endmodule : sco_window

// ==== tb/tb_top.sv ====
// testbench: system configuration options registers over apb
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wd;
    logic [3:0]  ratio;
  } sco_row_t;
  logic        clk_in          = 1'b0;
  logic        rstn_in         = 1'b0;
  logic        psel_in         = 1'b0;
  logic        penable_in      = 1'b0;
  logic        pwrite_in       = 1'b0;
  logic [11:0] paddr_in        = 12'h000;
  logic [31:0] pwdata_in       = 32'h0;
  logic        secure_in       = 1'b0;
  logic        clk_slow_in     = 1'b0;
  logic [15:0] ext_addr_in     = 16'h8000;
  logic        rom_high_map_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        converter_power_up_out;
  logic        charge_pump_clock_select_out;
  logic        interrupt_pin_edge_select_out;
  logic        startup_delay_enable_out;
  logic        clock_monitor_active_out;
  logic        clock_fail_reset_out;
  logic [1:0]  watchdog_rate_select_out;
  logic        instr_strobe_drive_high_out;
  logic        port_c_open_drain_out;
  logic        stretch_active_out;
  logic        internal_read_visibility_out;
  logic        e_clock_suppress_out;
  logic        serial_bit_order_out;
  logic        serial_extra_divide_out;
  logic [1:0]  aux_clock_divide_out;
  logic [3:0]  aux_divide_ratio_out;
  logic [31:0] rd_val;
  logic        err_val;
  int          error_cnt = 0;
  int          n_tests   = 0;
  localparam int ADC_WAIT_CYC = 25000; // 100 us of 4 ns cycles
  localparam int AUX_WAIT_CYC = 16;
  wire logic [7:0] one_out = {converter_power_up_out,
    charge_pump_clock_select_out, interrupt_pin_edge_select_out,
    startup_delay_enable_out, clock_monitor_active_out, 1'b0,
    watchdog_rate_select_out};
  wire logic [7:0] two_out = {instr_strobe_drive_high_out,
    port_c_open_drain_out, stretch_active_out, e_clock_suppress_out,
    serial_bit_order_out, serial_extra_divide_out, aux_clock_divide_out};
  wire logic [3:0] pins_out = {instr_strobe_drive_high_out,
    stretch_active_out, internal_read_visibility_out,
    e_clock_suppress_out};
  // boot mode rows: write value and expected divide ratio
  sco_row_t rows [10] = '{
    '{sco_pkg::OPT_ONE_ADDR, 8'ha1, 4'h0},
    '{sco_pkg::OPT_ONE_ADDR, 8'h5a, 4'h0},
    '{sco_pkg::OPT_ONE_ADDR, 8'h00, 4'h0},
    '{sco_pkg::OPT_ONE_ADDR, 8'hf9, 4'h0},
    '{sco_pkg::OPT_TWO_ADDR, 8'h00, 4'h1},
    '{sco_pkg::OPT_TWO_ADDR, 8'h51, 4'h4},
    '{sco_pkg::OPT_TWO_ADDR, 8'hae, 4'h6},
    '{sco_pkg::OPT_TWO_ADDR, 8'h1b, 4'h8},
    '{sco_pkg::OPT_TWO_ADDR, 8'hff, 4'h8},
    '{sco_pkg::OPT_TWO_ADDR, 8'h00, 4'h1}};

  sco_top uut (
    .clk_in                        (clk_in),
    .rstn_in                       (rstn_in),
    .psel_in                       (psel_in),
    .penable_in                    (penable_in),
    .pwrite_in                     (pwrite_in),
    .paddr_in                      (paddr_in),
    .pwdata_in                     (pwdata_in),
    .prdata_out                    (prdata_out),
    .pready_out                    (pready_out),
    .pslverr_out                   (pslverr_out),
    .secure_in                     (secure_in),
    .clk_slow_in                   (clk_slow_in),
    .ext_addr_in                   (ext_addr_in),
    .rom_high_map_in               (rom_high_map_in),
    .converter_power_up_out        (converter_power_up_out),
    .charge_pump_clock_select_out  (charge_pump_clock_select_out),
    .interrupt_pin_edge_select_out (interrupt_pin_edge_select_out),
    .startup_delay_enable_out      (startup_delay_enable_out),
    .clock_monitor_active_out      (clock_monitor_active_out),
    .clock_fail_reset_out          (clock_fail_reset_out),
    .watchdog_rate_select_out      (watchdog_rate_select_out),
    .instr_strobe_drive_high_out   (instr_strobe_drive_high_out),
    .port_c_open_drain_out         (port_c_open_drain_out),
    .stretch_active_out            (stretch_active_out),
    .internal_read_visibility_out  (internal_read_visibility_out),
    .e_clock_suppress_out          (e_clock_suppress_out),
    .serial_bit_order_out          (serial_bit_order_out),
    .serial_extra_divide_out       (serial_extra_divide_out),
    .aux_clock_divide_out          (aux_clock_divide_out),
    .aux_divide_ratio_out          (aux_divide_ratio_out)
  );

  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer, waits for ready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= {24'h0, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd_val     = prdata_out;
    err_val    = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask : apb

  task automatic settle;
    repeat (2) @(posedge clk_in);
  endtask : settle

  task automatic do_reset;
    rstn_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask : do_reset
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    apb(1'b1, sco_pkg::MODE_ADDR, 8'h02);
    repeat (70) @(posedge clk_in);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wd);
      if (rows[i].addr === sco_pkg::OPT_ONE_ADDR && rows[i].wd[7]) begin
        repeat (ADC_WAIT_CYC) @(posedge clk_in);
      end
      settle();
      apb(1'b0, rows[i].addr, 8'h00);
      chk("row_read", rd_val, {24'h0, rows[i].wd});
      if (rows[i].addr === sco_pkg::OPT_ONE_ADDR) begin
        chk("row_one", one_out, rows[i].wd & 8'hfb);
      end else begin
        repeat (AUX_WAIT_CYC) @(posedge clk_in);
        chk("row_two", two_out, rows[i].wd & 8'h5f);
        chk("row_ratio", aux_divide_ratio_out, rows[i].ratio);
      end
    end
    apb(1'b1, sco_pkg::OPT_ONE_ADDR, 8'h04);
    settle();
    apb(1'b1, sco_pkg::OPT_ONE_ADDR, 8'h00);
    settle();
    apb(1'b0, sco_pkg::OPT_ONE_ADDR, 8'h00);
    chk("boot_clear", rd_val, 32'h00);
    chk("forced_hold", clock_monitor_active_out, 1'b1);
    $display("test boot done");
    do_reset();
    apb(1'b0, sco_pkg::OPT_ONE_ADDR, 8'h00);
    chk("one_reset", rd_val, 32'h10);
    chk("delay_reset", startup_delay_enable_out, 1'b1);
    chk("ratio_reset", aux_divide_ratio_out, 4'h1);
    apb(1'b0, sco_pkg::OPT_TWO_ADDR, 8'h00);
    chk("two_reset", rd_val, 32'h00);
    apb(1'b0, 12'h004, 8'h00);
    chk("unmapped_err", err_val, 1'b1);
    apb(1'b1, sco_pkg::OPT_ONE_ADDR, 8'hff);
    settle();
    apb(1'b0, sco_pkg::OPT_ONE_ADDR, 8'h00);
    chk("one_first", rd_val, 32'hff);
    chk("one_out_first", one_out, 8'hfb);
    apb(1'b1, sco_pkg::OPT_ONE_ADDR, 8'h00);
    settle();
    apb(1'b0, sco_pkg::OPT_ONE_ADDR, 8'h00);
    chk("one_second", rd_val, 32'h37);
    chk("one_out_second", one_out, 8'h3b);
    clk_slow_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk("fail_reset", clock_fail_reset_out, 1'b1);
    clk_slow_in <= 1'b0;
    apb(1'b1, sco_pkg::OPT_TWO_ADDR, 8'h30);
    settle();
    chk("single_pins", pins_out, 4'h1);
    apb(1'b1, sco_pkg::OPT_TWO_ADDR, 8'h00);
    settle();
    apb(1'b0, sco_pkg::OPT_TWO_ADDR, 8'h00);
    chk("vis_once", rd_val, 32'h10);
    chk("e_suppress", e_clock_suppress_out, 1'b1);
    $display("test single-chip done");
    do_reset();
    repeat (70) @(posedge clk_in);
    apb(1'b1, sco_pkg::OPT_ONE_ADDR, 8'heb);
    settle();
    apb(1'b0, sco_pkg::OPT_ONE_ADDR, 8'h00);
    chk("one_late", rd_val, 32'hd8);
    $display("test window done");
    do_reset();
    apb(1'b1, sco_pkg::MODE_ADDR, 8'h01);
    apb(1'b1, sco_pkg::OPT_TWO_ADDR, 8'hb0);
    settle();
    chk("exp_pins", pins_out, 4'he);
    ext_addr_in <= 16'h0000;
    settle();
    chk("exp_low_addr", pins_out, 4'ha);
    rom_high_map_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk("exp_rom_high", pins_out, 4'he);
    secure_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk("exp_secure", pins_out, 4'hc);
    $display("test expanded done");
    secure_in <= 1'b0;
    do_reset();
    apb(1'b1, sco_pkg::MODE_ADDR, 8'h03);
    settle();
    apb(1'b0, sco_pkg::OPT_TWO_ADDR, 8'h00);
    chk("test_vis", rd_val, 32'h10);
    $display("test special-test done");
    end_sim();
  end
endmodule : tb_top
